// ### rtl/pd_handshake_map.svh
// Offsets and timing counts of the process-data handshake block.
// Assumes a 40 MHz mclk and an AHB-Lite bus with 32-bit words.
`ifndef PD_HANDSHAKE_MAP_SVH
`define PD_HANDSHAKE_MAP_SVH
// Register byte addresses.
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_CCTL 12'h008
`define A_CSTAT 12'h00C
`define A_ACQ_CTL 12'h010
`define A_ACQ_STAT 12'h014
`define A_RES_CTL 12'h018
`define A_RES_STAT 12'h01C
`define A_ENGINE 12'h020
`define A_MODE 12'h024
// Timing: process image update period.
`define CYCLE_NS 25
`define UPDATE_MS 8
`define UPDATE_CYC ((`UPDATE_MS * 1000000) / `CYCLE_NS)
`endif

// ### rtl/pd_handshake_pkg.sv
// Types of the process-data handshake block.
// Assumes nothing beyond a SystemVerilog compiler.
package pd_handshake_pkg;
  typedef enum logic [2:0] {
    ST_OFFLINE = 3'b000,
    ST_ONLINE = 3'b001,
    ST_FINISH = 3'b011,
    ST_LOADING = 3'b010,
    ST_REFUSED = 3'b110
  } run_state_e;
endpackage : pd_handshake_pkg

// ### rtl/fieldbus_control_status_handshake.sv
// Run/stop, program switch, capture and result handshakes behind the cyclic process image.
// Assumes an AHB-Lite master on mclk; the vision engine takes the command outputs and reports through the engine register.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "pd_handshake_map.svh"

// Overview of operation
// - Status bit 0 shows online state.
// - Come up offline after reset.
// - Go online only with program loaded.
// - Set online echo after run attempt.
// - Finish inspection cycle before going offline.
// - Clear echo and online together.
// - Apply startup-program choice with switch.
// - Report switch done, success, active number.
// - Capture only when ready and fieldbus-triggered.
// - Capture echo follows capture request edges.
// - Ready high when capture can be accepted.
// - Compat control: offline, switch; ignore 2,4.
// - Compat bit 3 switches illumination off.
// - Compat status: online, fault 0, outcome.
// - Acquisition status carries next 16-bit identifier.
// - Acquisition status: ready, received, acquiring.
// - Honour result enable and acknowledge bits.
// - Results status: inspecting, toggle, verdicts, ID.
// - Keep only the latest result.
// - Process image refreshed every 8 ms.
module fieldbus_control_status_handshake #(
  parameter int UPDATE_CYCLES = `UPDATE_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Vision engine commands.
  output logic capture_start,
  output logic program_load_start,
  output logic [7:0] program_load_number,
  output logic program_load_startup,
  output logic engine_run,
  output logic illumination_on
);

  // Process image registers written by the bus.
  logic [15:0] ctrl_q;
  logic [15:0] cctl_q;
  logic [7:0] acq_ctl_q;
  logic [7:0] res_ctl_q;
  logic compat_q;
  // Sampled image that the handshake logic takes from the bus-written registers each update period.
  logic [15:0] ctrl_img_q;
  logic [15:0] cctl_img_q;
  logic [7:0] acq_img_q;
  logic [7:0] res_img_q;
  logic [31:0] upd_cnt_q;
  logic tick;
  // Engine feedback written by the engine side of the bus.
  logic [31:0] engine_q;
  logic [31:0] engine_wr;
  logic engine_pulse;
  // Handshake state.
  pd_handshake_pkg::run_state_e st_q;
  pd_handshake_pkg::run_state_e st_d;
  logic online_q;
  logic echo_q;
  logic loaded_q;
  logic [7:0] active_q;
  logic sw_done_q;
  logic sw_ok_q;
  logic sw_fail_q;
  logic busy_q;
  logic cap_echo_q;
  logic cap_prev_q;
  logic acquiring_q;
  logic [15:0] next_id_q;
  logic [15:0] res_id_q;
  logic inspecting_q;
  logic done_tgl_q;
  logic res_avail_q;
  logic any_fail_q;
  logic all_pass_q;
  // Previous image bits for edge detection; they reset low like the idle image.
  logic run_prev_q;
  logic sw_prev_q;
  // Bus data phase.
  logic wr_q;
  logic [11:0] wa_q;
  logic rd_pend;

  // The engine side reports over the same bus, so each write of its word is a one-cycle event.
  // Engine word fields: bit 0 inspection done pulse, bit 1 all pass, bit 2 load done,
  // bit 3 load ok, bit 4 acquisition finished, bit 5 fieldbus trigger source.
  assign engine_pulse = wr_q && (wa_q == `A_ENGINE);
  assign engine_wr = hwdata;

  // Address phase decode; only whole-word transfers are expected.
  // Data-phase hready needs no check: this slave never stretches a transfer.
  wire addr_ok = hsel && hready && htrans[1];
  assign rd_pend = addr_ok && !hwrite;

  // Update period divider; the control image is taken only at the period edge.
  // It runs from reset, so the first image is taken at most one period after release.
  assign tick = (upd_cnt_q == UPDATE_CYCLES - 1);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upd_cnt_q <= 32'h00000000;
    end else begin
      upd_cnt_q <= tick ? 32'h00000000 : upd_cnt_q + 32'h00000001;
    end
  end

  // Bus writes land in the staging registers; single-cycle data phase.
  // Hsize is not checked: a narrow write still replaces the whole field, so hosts write words.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      wa_q <= 12'h000;
      ctrl_q <= 16'h0000;
      cctl_q <= 16'h0000;
      acq_ctl_q <= 8'h00;
      res_ctl_q <= 8'h00;
      compat_q <= 1'b0;
      engine_q <= 32'h00000000;
    end else begin
      wr_q <= addr_ok && hwrite;
      // The address is kept every cycle; only wr_q decides whether it is used.
      wa_q <= haddr;
      if (wr_q) begin
        case (wa_q)
          `A_CTRL: ctrl_q <= hwdata[15:0];
          `A_CCTL: cctl_q <= hwdata[15:0];
          `A_ACQ_CTL: acq_ctl_q <= hwdata[7:0];
          `A_RES_CTL: res_ctl_q <= hwdata[7:0];
          `A_MODE: compat_q <= hwdata[0];
          `A_ENGINE: engine_q <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // Sample the control image once each update period.
  // This mimics the cyclic exchange: a control bit held for less than a period may be lost,
  // so the host must hold each bit until the matching status bit answers it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_img_q <= 16'h0000;
      cctl_img_q <= 16'h0000;
      acq_img_q <= 8'h00;
      res_img_q <= 8'h00;
    end else if (tick) begin
      ctrl_img_q <= ctrl_q;
      cctl_img_q <= cctl_q;
      acq_img_q <= acq_ctl_q;
      res_img_q <= res_ctl_q;
    end
  end

  // True in the states in which the engine executes a program, the finishing cycle included.
  function automatic logic is_running(input pd_handshake_pkg::run_state_e s);
    return (s == pd_handshake_pkg::ST_ONLINE) || (s == pd_handshake_pkg::ST_FINISH);
  endfunction : is_running

  // Decoded control bits of both layouts.
  // The compatibility layout asks to go offline, so its bit is inverted into a run request.
  wire run_req = compat_q ? ~cctl_img_q[0] : ctrl_img_q[0];
  wire sw_req = compat_q ? cctl_img_q[1] : ctrl_img_q[1];
  wire [7:0] req_num = compat_q ? cctl_img_q[15:8] : ctrl_img_q[15:8];
  wire startup = compat_q ? 1'b0 : ctrl_img_q[2];
  wire cap_req = compat_q ? acq_img_q[0] : ctrl_img_q[3];
  wire run_rise = run_req && !run_prev_q;
  wire sw_rise = sw_req && !sw_prev_q;
  wire insp_done = engine_pulse && engine_wr[0];
  wire load_done = engine_pulse && engine_wr[2];
  wire acq_done = engine_pulse && engine_wr[4];
  // Ready only while steadily online: a finishing cycle must not take a new capture,
  // otherwise the engine would be halted with an acquisition still owed to the host.
  wire ready = (st_q == pd_handshake_pkg::ST_ONLINE) && !busy_q;
  wire cap_go = cap_req && !cap_prev_q && ready && engine_q[5];
  wire res_ack = res_img_q[1];
  wire res_en = res_img_q[0];
  // A switch is taken only from offline, and a run request in the same image wins.
  wire sw_take = sw_rise && (st_q == pd_handshake_pkg::ST_OFFLINE) && !run_rise;
  // Next-state conditions shared by the status flags and the engine outputs.
  wire run_next = is_running(st_d);
  wire echo_next = is_running(st_d) || (st_d == pd_handshake_pkg::ST_REFUSED);

  // Next state of the run/switch machine.
  always_comb begin
    st_d = st_q;
    case (st_q)
      pd_handshake_pkg::ST_OFFLINE: begin
        if (run_rise) st_d = loaded_q ? pd_handshake_pkg::ST_ONLINE : pd_handshake_pkg::ST_REFUSED;
        else if (sw_rise) st_d = pd_handshake_pkg::ST_LOADING;
      end
      pd_handshake_pkg::ST_REFUSED: begin
        // The echo stands until the host drops its request.
        if (!run_req) st_d = pd_handshake_pkg::ST_OFFLINE;
      end
      pd_handshake_pkg::ST_ONLINE: begin
        if (!run_req) st_d = pd_handshake_pkg::ST_FINISH;
      end
      pd_handshake_pkg::ST_FINISH: begin
        // The program stays loaded; only execution halts once the cycle ends.
        if (!busy_q || insp_done) st_d = pd_handshake_pkg::ST_OFFLINE;
      end
      pd_handshake_pkg::ST_LOADING: begin
        // Run requests are not looked at until the load has been answered.
        if (load_done) st_d = pd_handshake_pkg::ST_OFFLINE;
      end
      default: st_d = pd_handshake_pkg::ST_OFFLINE;
    endcase
  end

  // Run, stop and program switch handshake.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= pd_handshake_pkg::ST_OFFLINE;
      online_q <= 1'b0;
      echo_q <= 1'b0;
      loaded_q <= 1'b0;
      active_q <= 8'h00;
      sw_done_q <= 1'b0;
      sw_ok_q <= 1'b0;
      sw_fail_q <= 1'b0;
      run_prev_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      run_prev_q <= run_req;
      sw_prev_q <= sw_req;
      online_q <= run_next;
      // Echo rises when an attempt ends and falls with online, so a cleared echo means stopped.
      echo_q <= echo_next;
      if (sw_take) begin
        sw_done_q <= 1'b0;
        sw_fail_q <= 1'b0;
      end else if (load_done && st_q == pd_handshake_pkg::ST_LOADING) begin
        sw_done_q <= 1'b1;
        sw_ok_q <= engine_wr[3];
        sw_fail_q <= !engine_wr[3];
        // A failed load keeps the previous program and number in force.
        if (engine_wr[3]) begin
          active_q <= program_load_number;
          loaded_q <= 1'b1;
        end
      end else if (!sw_req && st_q != pd_handshake_pkg::ST_LOADING) begin
        // The done flag stands until the host drops its request.
        sw_done_q <= 1'b0;
      end
    end
  end

  // Capture, acquisition and result handshake; only the latest result is kept.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cap_echo_q <= 1'b0;
      cap_prev_q <= 1'b0;
      acquiring_q <= 1'b0;
      next_id_q <= 16'h0000;
      res_id_q <= 16'h0000;
      inspecting_q <= 1'b0;
      done_tgl_q <= 1'b0;
      res_avail_q <= 1'b0;
      any_fail_q <= 1'b0;
      all_pass_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_req;
      // The echo follows the request's edges even when the capture itself is refused.
      if (cap_req && !cap_prev_q) cap_echo_q <= 1'b1;
      else if (!cap_req && cap_prev_q) cap_echo_q <= 1'b0;
      if (cap_go) begin
        busy_q <= 1'b1;
        acquiring_q <= 1'b1;
        inspecting_q <= 1'b1;
        // The identifier moves on at acceptance, so the status always shows the next one.
        res_id_q <= next_id_q;
        next_id_q <= next_id_q + 16'h0001;
      end else begin
        // Acquisition and inspection end separately; only the inspection frees the engine.
        if (acq_done) acquiring_q <= 1'b0;
        if (insp_done) begin
          busy_q <= 1'b0;
          inspecting_q <= 1'b0;
          done_tgl_q <= ~done_tgl_q;
          any_fail_q <= !engine_wr[1];
          all_pass_q <= engine_wr[1];
        end
      end
      // A new result overrides an acknowledge in the same cycle.
      // Dropping the enable discards a pending result, as no queue is kept.
      if (insp_done && res_en) res_avail_q <= 1'b1;
      else if (res_ack || !res_en) res_avail_q <= 1'b0;
    end
  end

  // Engine command outputs.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      capture_start <= 1'b0;
      program_load_start <= 1'b0;
      program_load_number <= 8'h00;
      program_load_startup <= 1'b0;
      engine_run <= 1'b0;
      illumination_on <= 1'b1;
    end else begin
      capture_start <= cap_go;
      program_load_start <= sw_take;
      if (sw_take) begin
        program_load_number <= req_num;
        program_load_startup <= startup;
      end
      engine_run <= run_next;
      // The standard layout has no way to switch the light off, so it stays on there.
      illumination_on <= !(compat_q && cctl_img_q[3]);
    end
  end

  // Status words as the host reads them.
  wire [15:0] stat_w = {active_q, 1'b0, cap_echo_q, ready, sw_ok_q, sw_done_q, 1'b0, echo_q, online_q};
  // Compatibility status: the general-fault bit is tied low, bit 5 needs a good load.
  wire [15:0] cstat_w = {9'h000, sw_fail_q, sw_done_q && sw_ok_q, 1'b0, 3'h0, online_q};
  // Acquisition status: the identifier is the one the next accepted capture will carry.
  wire [23:0] acq_w = {next_id_q, 5'h00, acquiring_q, cap_echo_q, ready};
  // Results status: unsupported bits read as zero so the host never sees stale values.
  wire [23:0] res_w = {1'b0, res_id_q, all_pass_q, any_fail_q, res_avail_q, 1'b0, done_tgl_q, inspecting_q, 1'b0};

  // Read mux, registered in the address phase so hrdata comes straight from a flop.
  // Unmapped offsets read as zero rather than raising an error response.
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr)
      `A_CTRL: rd_mux = {16'h0000, ctrl_q};
      `A_STAT: rd_mux = {16'h0000, stat_w};
      `A_CCTL: rd_mux = {16'h0000, cctl_q};
      `A_CSTAT: rd_mux = {16'h0000, cstat_w};
      `A_ACQ_CTL: rd_mux = {24'h000000, acq_ctl_q};
      `A_ACQ_STAT: rd_mux = {8'h00, acq_w};
      `A_RES_CTL: rd_mux = {24'h000000, res_ctl_q};
      `A_RES_STAT: rd_mux = {8'h00, res_w};
      `A_ENGINE: rd_mux = engine_q;
      `A_MODE: rd_mux = {31'h00000000, compat_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Zero wait state slave, always OKAY.
  // No transfer is ever refused, so hresp never leaves OKAY and no two-cycle error is needed.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_pend) hrdata <= rd_mux;
    end
  end

endmodule : fieldbus_control_status_handshake

// ### dv/fieldbus_control_status_handshake_checker.sv
// Concurrent checks on the ports of the process-data handshake block.
// Assumes one clock domain, mclk, and the active-low asynchronous reset rst_b.
`timescale 1ns/10ps
module pd_hs_checker #(
  parameter int UPDATE_CYCLES = 4
) (
  // Clock, reset and bus.
  input wire logic mclk, rst_b, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata, hrdata,
  // Engine commands.
  input wire logic capture_start, program_load_start, program_load_startup, engine_run, illumination_on,
  input wire logic [7:0] program_load_number
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Zero-wait slave with a fixed OKAY answer.
  bus_ready_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  reset_offline_a: assert property ($rose(rst_b) |-> !engine_run) else $error("run after reset");
  reset_light_a: assert property ($rose(rst_b) |-> illumination_on) else $error("light off after reset");
  // A capture is accepted only while a program runs, and only as a one-cycle pulse.
  cap_online_a: assert property (capture_start |-> engine_run) else $error("capture while offline");
  cap_pulse_a: assert property (capture_start |=> !capture_start) else $error("capture not a pulse");
  load_pulse_a: assert property (program_load_start |=> !program_load_start) else $error("load not a pulse");
  load_args_a: assert property (program_load_start |=> $stable(program_load_number) && $stable(program_load_startup))
    else $error("load arguments moved");
  load_idle_a: assert property (program_load_start |-> !capture_start) else $error("load during capture");
endmodule : pd_hs_checker
bind fieldbus_control_status_handshake pd_hs_checker #(.UPDATE_CYCLES(UPDATE_CYCLES)) pd_hs_checker_inst (
  .mclk, .rst_b, .hsel, .hwrite, .hready, .hreadyout, .hresp, .haddr, .htrans, .hsize, .hwdata, .hrdata,
  .capture_start, .program_load_start, .program_load_startup, .engine_run, .illumination_on, .program_load_number);

// ### dv/plc_master.sv
// PLC model: an AHB-Lite master that writes control words and reads status words.
// Assumes a single slave whose hreadyout is the bus's hready.
`timescale 1ns/10ps
module plc_master (
  // Clock.
  input wire logic mclk,
  // AHB-Lite master side.
  output logic hsel, hwrite,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout
);
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
  end
  // One single word transfer; released data is inverted so stale values never look valid.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask : xfer
  // Writes of the program number come before or with the switch bit, never after.
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask : rd
endmodule : plc_master

// ### dv/tb_fieldbus_control_status_handshake.sv
// Self-checking bench for the process-data handshake block.
// Assumes the PLC model drives the bus and the update tick is shortened to four cycles.
`timescale 1ns/10ps
`include "pd_handshake_map.svh"
module tb_fieldbus_control_status_handshake;
  logic mclk = 0, rst_b = 0, hsel, hwrite, hreadyout, hresp;
  logic capture_start, program_load_start, program_load_startup, engine_run, illumination_on;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [7:0] program_load_number;
  int n_mismatch = 0, n_checks = 0, n_cap = 0, n_load = 0, cyc = 0;
  fieldbus_control_status_handshake #(.UPDATE_CYCLES(4)) fieldbus_control_status_handshake_inst (
    .mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .capture_start, .program_load_start, .program_load_number, .program_load_startup, .engine_run,
    .illumination_on);
  plc_master plc_master_inst (.mclk, .hsel, .hwrite, .haddr, .htrans, .hsize, .hwdata, .hrdata, .hreadyout);
  always #12.5 mclk = ~mclk;
  // Capture pulses are counted; the timeout cuts a hang short.
  always @(posedge mclk) begin
    n_cap <= n_cap + int'(capture_start === 1'b1);
    n_load <= n_load + int'(program_load_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Reads a register and compares the bits under a mask.
  task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    plc_master_inst.rd(a, r);
    chk(r & m, exp);
  endtask : rchk
  // Control words only take effect at the next update tick, so let two ticks pass.
  task wsync(input logic [11:0] a, input logic [31:0] d);
    plc_master_inst.wr(a, d);
    repeat (10) @(posedge mclk);
  endtask : wsync
  task end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    logic [31:0] id0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rchk(`A_STAT, 32'h3, 32'h0);
    rchk(12'h100, 32'hFFFFFFFF, 32'h0);
    wsync(`A_CTRL, 32'h1);
    rchk(`A_STAT, 32'h3, 32'h2);
    wsync(`A_CTRL, 32'h0);
    rchk(`A_STAT, 32'h3, 32'h0);
    wsync(`A_CTRL, 32'h0506);
    chk({program_load_startup, program_load_number}, 32'h105);
    chk(n_load, 32'h1);
    wsync(`A_ENGINE, 32'hC);
    rchk(`A_STAT, 32'hFF1B, 32'h0518);
    wsync(`A_CTRL, 32'h0500);
    rchk(`A_STAT, 32'h8, 32'h0);
    wsync(`A_CTRL, 32'h0501);
    rchk(`A_STAT, 32'h3, 32'h3);
    chk(engine_run, 1'b1);
    wsync(`A_ENGINE, 32'h20);
    rchk(`A_STAT, 32'h20, 32'h20);
    plc_master_inst.rd(`A_ACQ_STAT, id0);
    wsync(`A_CTRL, 32'h0509);
    chk(n_cap, 32'h1);
    rchk(`A_STAT, 32'h60, 32'h40);
    rchk(`A_ACQ_STAT, 32'hFFFF00, (id0 + 32'h100) & 32'hFFFF00);
    wsync(`A_CTRL, 32'h0501);
    rchk(`A_STAT, 32'h40, 32'h0);
    wsync(`A_MODE, 32'h1);
    wsync(`A_CCTL, 32'h8);
    chk(illumination_on, 1'b0);
    rchk(`A_CSTAT, 32'h11, 32'h1);
    wsync(`A_RES_CTL, 32'h1);
    wsync(`A_ENGINE, 32'h23);
    rchk(`A_RES_STAT, 32'h70, 32'h50);
    wsync(`A_RES_CTL, 32'h3);
    rchk(`A_RES_STAT, 32'h10, 32'h0);
    wsync(`A_CCTL, 32'h1);
    rchk(`A_CSTAT, 32'h1, 32'h0);
    chk(engine_run, 1'b0);
    end_of_test();
  end
endmodule : tb_fieldbus_control_status_handshake
